// *** src/bwd_pkg.sv ***
// package: constants for the boot and runtime system watchdog
package bwd_pkg;
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned TICK_S         = 1;
  localparam int unsigned TICK_CYCLES    = CLK_HZ * TICK_S;
  localparam int unsigned TICK_W         = 26;
  localparam logic [7:0]  INTERVAL_MIN   = 8'h02;
  localparam logic [7:0]  INTERVAL_MAX   = 8'hFF;
  localparam logic [7:0]  INTERVAL_RESET = 8'hFF;
  localparam int unsigned RST_PULSE_US   = 1;
  localparam int unsigned RST_CYCLES     = (RST_PULSE_US * CLK_HZ) / 1_000_000;
  localparam logic [7:0]  RST_W_MAX      = 8'hFF;
  typedef enum logic [1:0] {
    BWD_IDLE,
    BWD_RUN,
    BWD_FIRE
  } bwd_state_e;
endpackage

// *** src/bwd_tick.sv ***
// one-second tick generator, restartable
`timescale 1ns/1ps
module bwd_tick #(
  parameter int unsigned CYCLES = bwd_pkg::TICK_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_restart,
  output logic      o_tick
);
  import bwd_pkg::*;
  logic [TICK_W-1:0] cnt;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else if (i_restart) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else if (cnt == TICK_W'(CYCLES - 1)) begin
      cnt    <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule

// *** src/bwd_system_watchdog.sv ***
// boot and runtime system watchdog: seconds countdown that resets the board
//
// Behaviour
// (R1) once armed, an unserviced interval ends in a full system reset pulse
// (R2) interval is whole seconds, 2 to 255; out-of-range values are clamped
// (R3) arming before the OS loads works the same; boot overrun resets the board
// (R4) software taking over after boot services or disarms it at once
// (R5) direct access and firmware service call both drive the same ports
// (R6) service reloads interval; counter drops each second tick; zero fires reset
`timescale 1ns/1ps
module bwd_system_watchdog #(
  parameter int unsigned TICK_CYCLES_P = bwd_pkg::TICK_CYCLES
) (
  input  wire logic       I_CLK,
  input  wire logic       I_NRST,
  input  wire logic       I_ARM,
  input  wire logic       I_DISARM,
  input  wire logic [7:0] I_INTERVAL,
  input  wire logic       I_SERVICE,
  output logic            O_ARMED,
  output logic [7:0]      O_REMAIN,
  output logic            O_SYS_RST_N,
  output logic            O_FIRED
);
  import bwd_pkg::*;

  bwd_state_e state;
  logic [7:0] interval;
  logic [7:0] count;
  logic [7:0] rst_cnt;
  logic       tick;
  logic       restart;
  logic [7:0] next_interval;

  // clamp keeps the interval legal whatever is written
  always_comb begin
    if (I_INTERVAL < INTERVAL_MIN) begin
      next_interval = INTERVAL_MIN; // R2
    end else begin
      next_interval = I_INTERVAL;
    end
  end

  // restarting the tick on arm/service gives full whole seconds
  assign restart = I_ARM | I_SERVICE | (state != BWD_RUN);

  bwd_tick #(
    .CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .i_clk     (I_CLK),
    .i_nrst    (I_NRST),
    .i_restart (restart),
    .o_tick    (tick)
  );

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      interval <= INTERVAL_RESET;
    end else if (I_ARM && state != BWD_FIRE) begin
      interval <= next_interval; // R2
    end
  end

  // state: idle until armed, running countdown, then fire
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= BWD_IDLE;
    end else begin
      unique case (state)
        BWD_IDLE: begin
          if (I_ARM) begin
            state <= BWD_RUN; // R3
          end
        end
        BWD_RUN: begin
          if (I_DISARM && !I_ARM) begin
            state <= BWD_IDLE; // R4
          end else if (tick && count == 8'h01 && !I_SERVICE && !I_ARM) begin
            state <= BWD_FIRE; // R1
          end
        end
        BWD_FIRE: begin
          if (rst_cnt == 8'h00) begin
            state <= BWD_IDLE;
          end
        end
        default: state <= BWD_IDLE;
      endcase
    end
  end

  // countdown: service and arm both reload
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      count <= 8'h00;
    end else if (state == BWD_FIRE) begin
      count <= 8'h00;
    end else if (I_ARM) begin
      count <= next_interval; // R6
    end else if (state == BWD_RUN && I_SERVICE) begin
      count <= interval; // R6 R5
    end else if (state == BWD_RUN && tick && count != 8'h00) begin
      count <= count - 8'h01; // R6
    end
  end

  // reset pulse width; fixed so the supervisor sees a clean low
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_cnt <= 8'h00;
    end else if (state == BWD_RUN) begin
      rst_cnt <= 8'(RST_CYCLES - 1);
    end else if (state == BWD_FIRE && rst_cnt != 8'h00) begin
      rst_cnt <= rst_cnt - 8'h01;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SYS_RST_N <= 1'b1;
      O_ARMED     <= 1'b0;
      O_REMAIN    <= 8'h00;
    end else begin
      O_SYS_RST_N <= !(state == BWD_FIRE); // R1
      O_ARMED     <= (state == BWD_RUN);
      O_REMAIN    <= count;
    end
  end

  // sticky cause flag, survives the pulse it caused; cleared by re-arm
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_FIRED <= 1'b0;
    end else if (state == BWD_RUN && tick && count == 8'h01 && !I_SERVICE && !I_ARM && !I_DISARM) begin
      O_FIRED <= 1'b1; // R1
    end else if (I_ARM) begin
      O_FIRED <= 1'b0;
    end
  end

  property p_fire_low;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_FIRE) |=> !O_SYS_RST_N;
  endproperty
  a_fire_low: assert property (p_fire_low) else $error("reset not driven on fire"); // R1

  property p_no_rst_idle;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_IDLE) |=> O_SYS_RST_N;
  endproperty
  a_no_rst_idle: assert property (p_no_rst_idle) else $error("reset while disarmed"); // R3

  property p_range;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_RUN) |-> (count <= interval) && (interval >= INTERVAL_MIN);
  endproperty
  a_range: assert property (p_range) else $error("count or interval out of range"); // R2

  property p_reload;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_RUN && I_SERVICE && !I_ARM && !I_DISARM) |=> (count == interval);
  endproperty
  a_reload: assert property (p_reload) else $error("service did not reload"); // R6

  property p_dec;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_RUN && tick && count > 8'h01 && !I_SERVICE && !I_ARM && !I_DISARM)
        |=> (count == $past(count) - 8'h01);
  endproperty
  a_dec: assert property (p_dec) else $error("counter did not step down"); // R6

  property p_hold;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_RUN && !tick && !I_SERVICE && !I_ARM) |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick"); // R6

  property p_expire;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_RUN && tick && count == 8'h01 && !I_SERVICE && !I_ARM && !I_DISARM)
        |=> ##1 !O_SYS_RST_N ##1 O_FIRED;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry did not reset"); // R1

  property p_disarm;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_RUN && I_DISARM && !I_ARM) |=> ##1 !O_ARMED;
  endproperty
  a_disarm: assert property (p_disarm) else $error("disarm ignored"); // R4

  // arming, refusal while idle, cause flag and end of the reset pulse
  property p_arm_load;
    @(posedge I_CLK) disable iff (!I_NRST)
      (I_ARM && state != BWD_FIRE)
        |=> (state == BWD_RUN) && (count == interval);
  endproperty
  a_arm_load: assert property (p_arm_load) else $error("arm did not load and start"); // R3

  property p_fired_clear;
    @(posedge I_CLK) disable iff (!I_NRST)
      I_ARM |=> !O_FIRED;
  endproperty
  a_fired_clear: assert property (p_fired_clear) else $error("arm left the cause flag set"); // R1

  property p_idle_stays;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_IDLE && !I_ARM)
        |=> (state == BWD_IDLE) && $stable(count);
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("idle watchdog moved"); // R1

  property p_pulse_end;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state == BWD_FIRE && rst_cnt == 8'h00) |=> ##1 O_SYS_RST_N;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("reset pulse did not end"); // R1

  property p_tick_run;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state != BWD_RUN) |=> !tick;
  endproperty
  a_tick_run: assert property (p_tick_run) else $error("tick while not running"); // R6
endmodule

// *** tb/tb.sv ***
// testbench: self-checking scenarios for the system watchdog
`timescale 1ns/1ps
module tb;
  import bwd_pkg::*;
  // short tick so a whole second costs only a few cycles
  localparam int unsigned T = 10;
  logic       I_CLK;
  logic       I_NRST;
  logic       I_ARM;
  logic       I_DISARM;
  logic [7:0] I_INTERVAL;
  logic       I_SERVICE;
  logic       O_ARMED;
  logic [7:0] O_REMAIN;
  logic       O_SYS_RST_N;
  logic       O_FIRED;
  int         n_errors;
  int         compares;
  int         n;
  logic [7:0] ivs [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};

  bwd_system_watchdog #(.TICK_CYCLES_P(T)) u_bwd_system_watchdog (
    .I_CLK      (I_CLK),
    .I_NRST     (I_NRST),
    .I_ARM      (I_ARM),
    .I_DISARM   (I_DISARM),
    .I_INTERVAL (I_INTERVAL),
    .I_SERVICE  (I_SERVICE),
    .O_ARMED    (O_ARMED),
    .O_REMAIN   (O_REMAIN),
    .O_SYS_RST_N(O_SYS_RST_N),
    .O_FIRED    (O_FIRED)
  );

  initial begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // arm, then let the two-edge answer latency pass
  task automatic arm(input logic [7:0] iv);
    @(negedge I_CLK);
    I_ARM = 1'b1;
    I_INTERVAL = iv;
    @(negedge I_CLK);
    I_ARM = 1'b0;
    repeat (2) @(negedge I_CLK);
  endtask

  task automatic strobe(input logic s, input logic d);
    I_SERVICE = s;
    I_DISARM = d;
    @(negedge I_CLK);
    I_SERVICE = 1'b0;
    I_DISARM = 1'b0;
    repeat (2) @(negedge I_CLK);
  endtask

  task automatic t_ranges;
    foreach (ivs[i]) begin
      arm(ivs[i]);
      chk(O_REMAIN, (ivs[i] < INTERVAL_MIN) ? INTERVAL_MIN : ivs[i]);
      chk({7'h00, O_ARMED}, 8'h01);
      strobe(1'b0, 1'b1);
      chk({7'h00, O_ARMED}, 8'h00);
    end
  endtask

  task automatic t_service;
    arm(8'h03);
    repeat (T + 2) @(negedge I_CLK);
    chk(O_REMAIN, 8'h02);
    // service first: a full 2T wait here would let the 3 s interval run out
    repeat (8) begin
      strobe(1'b1, 1'b0);
      chk(O_REMAIN, 8'h03);
      repeat (2 * T) @(negedge I_CLK);
    end
    chk({6'h00, O_SYS_RST_N, O_FIRED}, 8'h02);
    strobe(1'b0, 1'b1);
    strobe(1'b1, 1'b0);
    repeat (5 * T) @(negedge I_CLK);
    chk({6'h00, O_SYS_RST_N, O_ARMED}, 8'h02);
  endtask

  task automatic t_expire;
    arm(8'h02);
    n = 0;
    while (O_SYS_RST_N !== 1'b0) begin
      @(negedge I_CLK);
      n++;
      if (n > 3000) begin
        n_errors++;
        complete_run();
      end
    end
    chk({7'h00, n >= 2 * T - 4 && n <= 2 * T + 4}, 8'h01);
    n = 0;
    while (O_SYS_RST_N === 1'b0 && n < 3000) begin
      @(negedge I_CLK);
      n++;
    end
    chk({7'h00, n >= RST_CYCLES && n <= RST_CYCLES + 2}, 8'h01);
    chk({6'h00, O_FIRED, O_ARMED}, 8'h02);
    arm(8'h05);
    chk({6'h00, O_FIRED, O_ARMED}, 8'h01);
    strobe(1'b0, 1'b1);
  endtask

  initial begin
    n_errors = 0;
    compares = 0;
    I_NRST = 1'b0;
    I_ARM = 1'b0;
    I_DISARM = 1'b0;
    I_SERVICE = 1'b0;
    I_INTERVAL = 8'h00;
    repeat (8) @(negedge I_CLK);
    chk({O_SYS_RST_N, O_ARMED, O_FIRED, 5'h00}, 8'h80);
    I_NRST = 1'b1;
    t_ranges();
    t_service();
    t_expire();
    complete_run();
  end
endmodule
